// ### rtl/ees_cfg.svh
// Constants for the two-wire nonvolatile memory slave
`ifndef EES_CFG_SVH
`define EES_CFG_SVH
// Timing
`define EES_CLK_MHZ 250
`define EES_WRITE_TIME_MS 10
`define EES_LOAD_TIME_MS 10
`define EES_WRITE_CYCLES (`EES_WRITE_TIME_MS * 1000 * `EES_CLK_MHZ)
`define EES_LOAD_CYCLES (`EES_LOAD_TIME_MS * 1000 * `EES_CLK_MHZ)
`define EES_CNT_W 23
// Memory geometry
`define EES_MEM_DEPTH 512
`define EES_PTR_W 9
`define EES_PAGE_DEPTH 8
`define EES_PAGE_W 3
// Address code change
`define EES_CODE_ADDR 16'hff09
`define EES_UNLOCK_KEY 8'h5f
`define EES_KEY_RESET 8'hff
`define EES_CODE_RESET 3'h0
`define EES_CODE_MAX 8'h07
// Register offsets (byte addresses)
`define EES_OFS_KEY 4'h0
`define EES_OFS_STATUS 4'h4
// Status fields
`define EES_ST_BUSY 0
`define EES_ST_LOAD 1
`define EES_ST_CODE_LO 4
`define EES_ST_CODE_HI 6
// Framing
`define EES_BITS_PER_BYTE 4'h8
`define EES_RW_WRITE 1'b0
`endif

// ### rtl/ees_pkg.sv
// Types of the two-wire nonvolatile memory slave
package ees_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_RACK = 3'b100
  } ees_state_e;
  typedef enum logic [1:0] {
    SG_DEV = 2'b00,
    SG_AHI = 2'b01,
    SG_ALO = 2'b10,
    SG_DATA = 2'b11
  } ees_stage_e;
endpackage

// ### rtl/ees_slave.sv
// Two-wire slave front end of the 512-byte nonvolatile memory
// What this block does
// - Sample data on rise, change on fall
// - Data falls with clock high: start
// - Data rises with clock high: stop
// - Stop after read returns to standby
// - Stop after write starts timed write
// - Bytes of eight bits, ninth is acknowledge
// - Drive zero acknowledge after each write byte
// - Release after read byte; ack sends next
// - No ack then stop ends read
// - No ack, no stop: stay released
// - Start, then seven address bits plus direction
// - Type code high nibble, select code below
// - Select code must equal reference register
// - Mismatch means standby, transaction ignored
// - Direction zero writes, one reads
// - Reference loaded from stored code after reset
// - Code change needs unlock key first
// - Address two bytes, high first, MSB first
// - Byte and eight-byte page writes
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`include "ees_cfg.svh"

module ees_slave
  import ees_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE = 4'h5, // Arbitrary device type value
  parameter int WRITE_CYCLES = `EES_WRITE_CYCLES,
  parameter int LOAD_CYCLES = `EES_LOAD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ==========================================================
  // Pin synchronisers and glitch filter
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic scl_f_ff;
  logic sda_f_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    end
  end

  // Stages two and three must agree, so a one-cycle spike never counts
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
    end else begin
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_f_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_f_ff <= sda_sync_ff[2];
      end
    end
  end

  logic scl_p_ff;
  logic sda_p_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_p_ff <= 1'b1;
      sda_p_ff <= 1'b1;
    end else begin
      scl_p_ff <= scl_f_ff;
      sda_p_ff <= sda_f_ff;
    end
  end

  assign scl_rise = scl_f_ff & ~scl_p_ff;
  assign scl_fall = ~scl_f_ff & scl_p_ff;
  assign start_ev = scl_f_ff & scl_p_ff & sda_p_ff & ~sda_f_ff;
  assign stop_ev = scl_f_ff & scl_p_ff & ~sda_p_ff & sda_f_ff;

  // ==========================================================
  // Storage
  logic [7:0] mem [0:`EES_MEM_DEPTH-1];
  logic [7:0] page_buf [0:`EES_PAGE_DEPTH-1];
  logic [`EES_PAGE_DEPTH-1:0] page_vld_ff;
  logic [2:0] code_cell_ff = `EES_CODE_RESET; // Nonvolatile, kept across reset
  logic [2:0] ref_code_ff;
  logic [7:0] key_ff;

  // ==========================================================
  // Reference load after reset and write-cycle timer
  logic [`EES_CNT_W-1:0] load_cnt_ff;
  logic loading_ff;
  logic [`EES_CNT_W-1:0] busy_cnt_ff;
  logic busy_ff;
  logic commit;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      loading_ff <= 1'b1;
      load_cnt_ff <= '0;
      ref_code_ff <= `EES_CODE_RESET;
    end else if (loading_ff) begin
      load_cnt_ff <= load_cnt_ff + 1'b1;
      if (load_cnt_ff == `EES_CNT_W'(LOAD_CYCLES - 1)) begin
        loading_ff <= 1'b0;
        ref_code_ff <= code_cell_ff;
      end
    end
  end

  // ==========================================================
  // Byte engine
  ees_state_e state_ff;
  ees_stage_e stage_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] addr_hi_ff;
  logic [`EES_PTR_W-1:0] ptr_ff;
  logic [3:0] nbytes_ff;
  logic special_ff;
  logic rd_next_ff;
  logic ack_seen_ff;
  logic drive_ff;
  logic dev_match;
  logic [`EES_PAGE_W-1:0] pidx;

  assign pidx = ptr_ff[`EES_PAGE_W-1:0];
  assign dev_match = (shift_ff[7:4] == TYPE_CODE) && (shift_ff[3:1] == ref_code_ff)
    && !busy_ff && !loading_ff;
  assign commit = stop_ev && (stage_ff == SG_DATA) && (nbytes_ff != 4'h0)
    && (state_ff != ST_IDLE || !rd_next_ff);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      stage_ff <= SG_DEV;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      addr_hi_ff <= 8'h00;
      ptr_ff <= '0;
      nbytes_ff <= 4'h0;
      special_ff <= 1'b0;
      rd_next_ff <= 1'b0;
      ack_seen_ff <= 1'b0;
      drive_ff <= 1'b0;
      page_vld_ff <= '0;
    end else if (start_ev) begin
      state_ff <= ST_RX;
      stage_ff <= SG_DEV;
      cnt_ff <= 4'h0;
      drive_ff <= 1'b0;
      rd_next_ff <= 1'b0;
    end else if (stop_ev) begin
      state_ff <= ST_IDLE;
      stage_ff <= SG_DEV;
      drive_ff <= 1'b0;
      nbytes_ff <= 4'h0;
      page_vld_ff <= '0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (scl_rise && cnt_ff != `EES_BITS_PER_BYTE) begin
            shift_ff <= {shift_ff[6:0], sda_f_ff};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == `EES_BITS_PER_BYTE) begin
            state_ff <= ST_ACK;
            drive_ff <= 1'b1;
            case (stage_ff)
              SG_DEV: begin
                if (!dev_match) begin
                  state_ff <= ST_IDLE;
                  drive_ff <= 1'b0;
                end else if (shift_ff[0] == `EES_RW_WRITE) begin
                  stage_ff <= SG_AHI;
                end else begin
                  rd_next_ff <= 1'b1;
                end
              end
              SG_AHI: begin
                addr_hi_ff <= shift_ff;
                stage_ff <= SG_ALO;
              end
              SG_ALO: begin
                ptr_ff <= {addr_hi_ff[0], shift_ff};
                special_ff <= ({addr_hi_ff, shift_ff} == `EES_CODE_ADDR);
                stage_ff <= SG_DATA;
                nbytes_ff <= 4'h0;
                page_vld_ff <= '0;
              end
              default: begin
                page_buf[pidx] <= shift_ff;
                page_vld_ff[pidx] <= 1'b1;
                ptr_ff <= {ptr_ff[`EES_PTR_W-1:`EES_PAGE_W], pidx + 1'b1}; // Roll within page
                if (nbytes_ff != 4'hf) begin
                  nbytes_ff <= nbytes_ff + 4'h1;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_ff <= 4'h0;
            if (rd_next_ff) begin
              tx_ff <= {mem[ptr_ff][6:0], 1'b0};
              drive_ff <= ~mem[ptr_ff][7];
              ptr_ff <= ptr_ff + 1'b1;
              cnt_ff <= 4'h1;
              state_ff <= ST_TX;
            end else begin
              drive_ff <= 1'b0;
              state_ff <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == `EES_BITS_PER_BYTE) begin
              drive_ff <= 1'b0;
              state_ff <= ST_RACK;
            end else begin
              drive_ff <= ~tx_ff[7];
              tx_ff <= {tx_ff[6:0], 1'b0};
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ack_seen_ff <= ~sda_f_ff;
            if (sda_f_ff) begin
              state_ff <= ST_IDLE;
            end
          end else if (scl_fall && ack_seen_ff) begin
            tx_ff <= {mem[ptr_ff][6:0], 1'b0};
            drive_ff <= ~mem[ptr_ff][7];
            ptr_ff <= ptr_ff + 1'b1;
            cnt_ff <= 4'h1;
            ack_seen_ff <= 1'b0;
            state_ff <= ST_TX;
          end
        end
        ST_IDLE: begin
          drive_ff <= 1'b0;
        end
        default: begin
          state_ff <= ST_IDLE;
          drive_ff <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = drive_ff;

  // ==========================================================
  // Timed write to the array at stop
  logic code_write;
  assign code_write = special_ff && (nbytes_ff == 4'h1) && (key_ff == `EES_UNLOCK_KEY)
    && (page_buf[pidx - 1'b1] <= `EES_CODE_MAX);

  always_ff @(posedge ref_clk) begin
    if (commit && !special_ff) begin
      for (int i = 0; i < `EES_PAGE_DEPTH; i++) begin
        if (page_vld_ff[i]) begin
          mem[{ptr_ff[`EES_PTR_W-1:`EES_PAGE_W], `EES_PAGE_W'(i)}] <= page_buf[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (commit && code_write) begin
      code_cell_ff <= page_buf[pidx - 1'b1][2:0];
    end
  end

  // Bus is deaf to this device until the write cycle ends
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
      busy_cnt_ff <= '0;
    end else if (commit) begin
      busy_ff <= 1'b1;
      busy_cnt_ff <= '0;
    end else if (busy_ff) begin
      busy_cnt_ff <= busy_cnt_ff + 1'b1;
      if (busy_cnt_ff == `EES_CNT_W'(WRITE_CYCLES - 1)) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Wishbone slave
  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `EES_OFS_KEY: wb_dat_o[7:0] <= key_ff;
          `EES_OFS_STATUS: begin
            wb_dat_o[`EES_ST_BUSY] <= busy_ff;
            wb_dat_o[`EES_ST_LOAD] <= loading_ff;
            wb_dat_o[`EES_ST_CODE_HI:`EES_ST_CODE_LO] <= ref_code_ff;
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      key_ff <= `EES_KEY_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `EES_OFS_KEY) begin
      key_ff <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // Checks
  sequence byte_in_s;
    state_ff == ST_RX && cnt_ff == `EES_BITS_PER_BYTE && scl_fall && !start_ev && !stop_ev;
  endsequence
  sequence nack_s;
    state_ff == ST_RACK && scl_rise && sda_f_ff && !start_ev && !stop_ev;
  endsequence

  start_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start_ev |=> state_ff == ST_RX && cnt_ff == 4'h0)
    else $error("start not taken");
  stop_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stop_ev |=> state_ff == ST_IDLE && !drive_ff)
    else $error("stop did not idle");
  stop_commit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    commit |=> busy_ff [*8])
    else $error("write cycle not held");
  rx_sample_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state_ff == ST_RX && scl_rise && cnt_ff != `EES_BITS_PER_BYTE && !start_ev && !stop_ev
    |=> shift_ff[0] == $past(sda_f_ff))
    else $error("bit not sampled on rise");
  drive_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(drive_ff) |-> $past(scl_fall) || $past(start_ev) || $past(stop_ev))
    else $error("output changed off falling edge");
  mismatch_ign_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    byte_in_s and (stage_ff == SG_DEV && !dev_match) |=> state_ff == ST_IDLE && !drive_ff)
    else $error("mismatched address acknowledged");
  write_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    byte_in_s and (stage_ff != SG_DEV) |=> drive_ff && state_ff == ST_ACK)
    else $error("write byte not acknowledged");
  nack_release_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    nack_s |=> state_ff == ST_IDLE && !drive_ff ##1 !drive_ff)
    else $error("drove after missing acknowledge");
  load_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    loading_ff |-> !drive_ff)
    else $error("answered during address load");
  code_key_a: assert property (@(posedge ref_clk)
    $changed(code_cell_ff) |-> $past(key_ff) == `EES_UNLOCK_KEY)
    else $error("address code changed without key");

endmodule

// ### tb/ees_mst.sv
// Two-wire bus master model for the memory slave bench
module ees_mst (
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sda_oe = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Bit timing
  // Quarter of a 125 ns bench bit, free of the system clock
  // Scaled far above a real master's 400 kHz ceiling to keep runs short
  task automatic q();
    #31.25;
  endtask
  // Clock parks high between frames, only start moves it
  task automatic start();
    sda_oe <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // ====================
  // Byte framing
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic byte_rx(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(mack, r);
  endtask
endmodule

// ### tb/ees_slave_bench.sv
// Self-checking bench of the two-wire memory slave
`include "ees_cfg.svh"
module ees_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOADC = 600;
  localparam int WRC = 1000;
  localparam logic [3:0] TC = 4'h5; // Arbitrary type value
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wwe = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic dut_out;
  logic dut_oe;
  logic mst_oe;
  wire scl;
  wire sda = ~mst_oe & (dut_oe ? dut_out : 1'b1);
  logic scl_q;
  logic oe_q;
  int error_cnt = 0;
  int check_count = 0;
  always #2 ref_clk = ~ref_clk;
  ees_slave #(.TYPE_CODE(TC), .WRITE_CYCLES(WRC), .LOAD_CYCLES(LOADC)) dut_u (.ref_clk(ref_clk),
    .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(dut_out), .sda_oe(dut_oe), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  ees_mst mst_u (.sda(sda), .scl(scl), .sda_oe(mst_oe));
  // ====================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Device output may only move while the clock is low
  always @(posedge ref_clk) begin
    scl_q <= scl;
    oe_q <= dut_oe;
    if (scl && scl_q && dut_oe !== oe_q) begin
      error_cnt++;
      $display("[FAIL] %0t data moved with clock high", $time);
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= we;
    adr <= a;
    wdat <= d;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(n, 32'h2, "bus answer");
  endtask
  task automatic sel_dev(input logic [2:0] c, input logic rw, output logic a);
    mst_u.start();
    mst_u.byte_tx({TC, c, rw}, a);
  endtask
  task automatic addr_ph(input logic [15:0] ma, output logic a);
    logic a0;
    logic a1;
    sel_dev(3'h0, 1'b0, a0);
    mst_u.byte_tx(ma[15:8], a1);
    mst_u.byte_tx(ma[7:0], a);
    a = a | a0 | a1;
  endtask
  task automatic rd(input logic [15:0] ma, input int n, input logic [7:0] e [8]);
    logic a;
    logic b;
    logic [7:0] d;
    addr_ph(ma, a);
    sel_dev(3'h0, 1'b1, b);
    chk({a, b}, 2'b00, "read addressing");
    for (int i = 0; i < n; i++) begin
      mst_u.byte_rx(i == n - 1, d);
      chk(d, e[i], "read data");
    end
    mst_u.stop();
  endtask
  task automatic wr_wait(input logic [15:0] ma, input logic [7:0] d);
    logic a;
    logic b;
    addr_ph(ma, a);
    mst_u.byte_tx(d, b);
    mst_u.stop();
    chk({a, b}, 2'b00, "write acks");
    repeat (WRC + 50) @(posedge ref_clk);
  endtask
  // ====================
  // Scenarios
  task automatic t_regs();
    logic [31:0] q;
    logic a;
    wb(1'b0, `EES_OFS_KEY, 32'h0, q);
    chk(q, 32'hff, "key reset");
    wb(1'b0, `EES_OFS_STATUS, 32'h0, q);
    chk(q[1], 1'b1, "loading flag");
    sel_dev(3'h0, 1'b0, a);
    mst_u.stop();
    chk(a, 1'b1, "access during load");
    repeat (LOADC) @(posedge ref_clk);
    wb(1'b0, `EES_OFS_STATUS, 32'h0, q);
    chk(q[6:0], 7'h0, "status after load");
    wb(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, `EES_OFS_KEY, 32'h5a, q);
    wb(1'b0, `EES_OFS_KEY, 32'h0, q);
    chk(q, 32'h5a, "key readback");
  endtask
  task automatic t_write();
    logic a;
    logic b;
    logic [31:0] q;
    addr_ph(16'h0010, a);
    mst_u.byte_tx(8'ha5, b);
    mst_u.stop();
    chk({a, b}, 2'b00, "byte write acks");
    wb(1'b0, `EES_OFS_STATUS, 32'h0, q);
    chk(q[0], 1'b1, "busy after stop");
    sel_dev(3'h0, 1'b0, a);
    mst_u.stop();
    chk(a, 1'b1, "poll while busy");
    repeat (WRC) @(posedge ref_clk);
    sel_dev(3'h0, 1'b0, a);
    mst_u.stop();
    chk(a, 1'b0, "poll after write");
    rd(16'h0010, 1, '{8'ha5, 0, 0, 0, 0, 0, 0, 0});
  endtask
  task automatic t_page();
    logic a;
    logic b;
    addr_ph(16'h001e, a);
    for (int i = 0; i < 9; i++) begin
      mst_u.byte_tx(8'h30 + 8'(i), b);
      a = a | b;
    end
    mst_u.stop();
    chk(a, 1'b0, "page acks");
    repeat (WRC + 50) @(posedge ref_clk);
    rd(16'h0018, 8, '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h31});
  endtask
  task automatic t_hold();
    logic a;
    logic [7:0] d;
    addr_ph(16'h001e, a);
    sel_dev(3'h0, 1'b1, a);
    mst_u.byte_rx(1'b1, d);
    chk(d, 8'h38, "read before nack");
    mst_u.byte_rx(1'b1, d);
    chk(d, 8'hff, "released after nack");
    mst_u.stop();
    rd(16'h0010, 1, '{8'ha5, 0, 0, 0, 0, 0, 0, 0});
  endtask
  task automatic t_select();
    logic a;
    logic b;
    mst_u.start();
    mst_u.byte_tx({TC ^ 4'h8, 3'h0, 1'b0}, a);
    mst_u.byte_tx(8'h00, b);
    mst_u.stop();
    chk({a, b}, 2'b11, "wrong type ignored");
    for (int c = 1; c < 8; c++) begin
      sel_dev(3'(c), 1'b0, a);
      mst_u.stop();
      chk(a, 1'b1, "wrong code refused");
    end
  endtask
  task automatic t_code();
    logic a;
    logic [31:0] q;
    wr_wait(`EES_CODE_ADDR, 8'h06);
    do_reset();
    repeat (LOADC + 20) @(posedge ref_clk);
    wb(1'b0, `EES_OFS_STATUS, 32'h0, q);
    chk(q[6:4], 3'h0, "code kept while locked");
    wb(1'b1, `EES_OFS_KEY, {24'h0, `EES_UNLOCK_KEY}, q);
    wr_wait(`EES_CODE_ADDR, 8'h07);
    do_reset();
    repeat (LOADC + 20) @(posedge ref_clk);
    wb(1'b0, `EES_OFS_STATUS, 32'h0, q);
    chk(q[6:4], 3'h7, "new code loaded");
    sel_dev(3'h0, 1'b0, a);
    mst_u.stop();
    chk(a, 1'b1, "old code refused");
    sel_dev(3'h7, 1'b0, a);
    mst_u.stop();
    chk(a, 1'b0, "new code selects");
  endtask
  // ====================
  // Sequence and watchdog
  initial begin
    do_reset();
    t_regs();
    $display("test regs done");
    t_write();
    $display("test write done");
    t_page();
    $display("test page done");
    t_hold();
    $display("test hold done");
    t_select();
    $display("test select done");
    t_code();
    $display("test code done");
    tally_and_finish();
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
